// file: inc/rca_pkg.sv
/*
  shared constants and types of the clock calibration and alarm block.
  assumes the clock digits arrive packed two-digit per byte, as the
  timekeeping counters of the clock unit hold them.
*/
package rca_pkg;

  // register bus geometry
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  ADDR_CAL     = 8'h00;
  localparam logic [7:0]  ADDR_ALCFG   = 8'h04;
  localparam logic [7:0]  ADDR_ALTIME  = 8'h08;
  localparam logic [7:0]  ADDR_ALDATE  = 8'h0c;
  localparam logic [7:0]  ADDR_STAT    = 8'h10;
  localparam logic [7:0]  ADDR_MASK    = 8'h14;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // reset values
  localparam logic [7:0]  CAL_RST      = 8'h00;
  localparam logic [15:0] ALCFG_RST    = 16'h0000;
  localparam logic [47:0] ALVAL_RST    = 48'h0000_0000_0000;
  localparam logic [1:0]  IRQ_RST      = 2'h0;

  // interrupt status bit positions
  localparam int          IRQ_ALARM    = 0;
  localparam int          IRQ_CAL      = 1;

  // repeat counter and minute boundary
  localparam logic [7:0]  RPT_LAST     = 8'h00;
  localparam logic [7:0]  RPT_ROLL     = 8'hff;
  localparam logic [7:0]  SEC_LAST     = 8'h59;

  typedef enum logic [3:0] {
    RCA_M_HALF_SEC = 4'b0000,
    RCA_M_SEC      = 4'b0001,
    RCA_M_10SEC    = 4'b0010,
    RCA_M_MIN      = 4'b0011,
    RCA_M_10MIN    = 4'b0100,
    RCA_M_HOUR     = 4'b0101,
    RCA_M_DAY      = 4'b0110,
    RCA_M_WEEK     = 4'b0111,
    RCA_M_MONTH    = 4'b1000,
    RCA_M_YEAR     = 4'b1001
  } rca_mask_e;

  typedef struct packed {
    logic [7:0] month;
    logic [7:0] day;
    logic [7:0] wday;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } rca_time_s;

  typedef struct packed {
    logic       en;
    logic       endless_repeat;
    logic [3:0] mask;
    logic [1:0] rsv;
    logic [7:0] rpt;
  } rca_alcfg_s;

  typedef struct packed {
    logic       add;
    logic       sub;
    logic [9:0] count;
  } rca_cal_adj_s;

endpackage : rca_pkg

// file: logic/rca_top.sv
/*
  calibration and alarm logic of the real-time clock, with an axi4-lite
  register slave and a masked interrupt.
  assumes the seconds and half-second ticks and the clock digits come from
  the timekeeping counters on the same clock, one-cycle ticks.
*/
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module rca_top (
  // clock and reset
  input  logic                       mclk,
  input  logic                       sys_rst,
  // timekeeping side
  input  logic                       half_sec_tick,
  input  logic                       sec_tick,
  input  rca_pkg::rca_time_s         clock_now,
  output rca_pkg::rca_cal_adj_s      cal_adj,
  output logic                       alarm_pulse,
  output logic                       irq,
  // axi4-lite write
  input  logic [rca_pkg::ADDR_W-1:0] awaddr,
  input  logic                       awvalid,
  output logic                       awready,
  input  logic [31:0]                wdata,
  input  logic [3:0]                 wstrb,
  input  logic                       wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  logic                       bready,
  // axi4-lite read
  input  logic [rca_pkg::ADDR_W-1:0] araddr,
  input  logic                       arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  logic                       rready
);
  import rca_pkg::*;

  logic [7:0]          rtc_config_calibration_ff;
  rca_alcfg_s          alarm_config_repeat_ff;
  rca_time_s           alarm_value_ff;
  logic [1:0]          irq_stat_ff;
  logic [1:0]          irq_mask_ff;
  rca_cal_adj_s        cal_adj_ff;
  logic                alarm_pulse_ff;
  logic                irq_ff;
  logic [ADDR_W-1:0]   awaddr_ff;
  logic [31:0]         wdata_ff;
  logic [3:0]          wstrb_ff;
  logic                aw_got_ff;
  logic                w_got_ff;
  logic                awready_ff;
  logic                wready_ff;
  logic                bvalid_ff;
  logic [1:0]          bresp_ff;
  logic                arready_ff;
  logic                rvalid_ff;
  logic [31:0]         rdata_ff;
  logic [1:0]          rresp_ff;

  // register view, shared by read path and byte-merge of writes
  function automatic logic [32:0] reg_view(input logic [ADDR_W-1:0] a, input logic [7:0] cal,
                                           input rca_alcfg_s cfg, input rca_time_s av,
                                           input logic [1:0] st, input logic [1:0] mk);
    logic [ADDR_W-1:0] wa;
    wa = {a[ADDR_W-1:2], 2'b00};
    if (wa == ADDR_CAL)         reg_view = {1'b1, 24'h0, cal};
    else if (wa == ADDR_ALCFG)  reg_view = {1'b1, 16'h0, cfg};
    else if (wa == ADDR_ALTIME) reg_view = {1'b1, 8'h0, av.hour, av.min, av.sec};
    else if (wa == ADDR_ALDATE) reg_view = {1'b1, 8'h0, av.month, av.day, av.wday};
    else if (wa == ADDR_STAT)   reg_view = {1'b1, 30'h0, st};
    else if (wa == ADDR_MASK)   reg_view = {1'b1, 30'h0, mk};
    else                        reg_view = {1'b0, 32'h0};
  endfunction : reg_view

  // write channel handshake
  wire aw_take = awvalid & awready_ff;
  wire w_take  = wvalid & wready_ff;
  wire do_wr   = aw_got_ff & w_got_ff;
  wire nxt_aw_got = (aw_got_ff | aw_take) & ~do_wr;
  wire nxt_w_got  = (w_got_ff | w_take) & ~do_wr;
  wire nxt_bvalid = do_wr | (bvalid_ff & ~bready);

  logic [31:0] byte_mask;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign byte_mask[gi*8 +: 8] = {8{wstrb_ff[gi]}};
    end
  endgenerate

  wire [32:0] wr_view  = reg_view(awaddr_ff, rtc_config_calibration_ff, alarm_config_repeat_ff,
                                  alarm_value_ff, irq_stat_ff, irq_mask_ff);
  wire [31:0] wr_word  = (wr_view[31:0] & ~byte_mask) | (wdata_ff & byte_mask);
  wire [31:0] w1c_bits = wdata_ff & byte_mask;
  wire [ADDR_W-1:0] wr_wa = {awaddr_ff[ADDR_W-1:2], 2'b00};
  wire wr_cal    = do_wr & (wr_wa == ADDR_CAL);
  wire wr_cfg    = do_wr & (wr_wa == ADDR_ALCFG);
  wire wr_time   = do_wr & (wr_wa == ADDR_ALTIME);
  wire wr_date   = do_wr & (wr_wa == ADDR_ALDATE);
  wire wr_stat   = do_wr & (wr_wa == ADDR_STAT);
  wire wr_mask   = do_wr & (wr_wa == ADDR_MASK);

  // read channel handshake
  wire ar_take    = arvalid & arready_ff;
  wire nxt_rvalid = ar_take | (rvalid_ff & ~rready);
  wire [32:0] rd_view = reg_view(araddr, rtc_config_calibration_ff, alarm_config_repeat_ff,
                                 alarm_value_ff, irq_stat_ff, irq_mask_ff);

  // digit comparison
  wire sec_eq   = clock_now.sec == alarm_value_ff.sec;
  wire sec1_eq  = clock_now.sec[3:0] == alarm_value_ff.sec[3:0];
  wire min_eq   = clock_now.min == alarm_value_ff.min;
  wire min1_eq  = clock_now.min[3:0] == alarm_value_ff.min[3:0];
  wire hour_eq  = clock_now.hour == alarm_value_ff.hour;
  wire wday_eq  = clock_now.wday == alarm_value_ff.wday;
  wire day_eq   = clock_now.day == alarm_value_ff.day;
  wire month_eq = clock_now.month == alarm_value_ff.month;
  wire hms_eq   = sec_eq & min_eq & hour_eq;
  rca_mask_e   cur_mask;
  assign cur_mask = rca_mask_e'(alarm_config_repeat_ff.mask);
  logic digit_match;
  logic use_half;
  always_comb begin
    use_half = 1'b0;
    unique case (cur_mask)
      RCA_M_HALF_SEC: begin
        digit_match = 1'b1;
        use_half    = 1'b1;
      end
      RCA_M_SEC:   digit_match = 1'b1;
      RCA_M_10SEC: digit_match = sec1_eq;
      RCA_M_MIN:   digit_match = sec_eq;
      RCA_M_10MIN: digit_match = sec_eq & min1_eq;
      RCA_M_HOUR:  digit_match = sec_eq & min_eq;
      RCA_M_DAY:   digit_match = hms_eq;
      RCA_M_WEEK:  digit_match = hms_eq & wday_eq;
      RCA_M_MONTH: digit_match = hms_eq & day_eq;
      RCA_M_YEAR:  digit_match = hms_eq & day_eq & month_eq;
      // reserved codes never fire rather than fire on every tick
      default:     digit_match = 1'b0;
    endcase
  end
  wire alarm_tick = use_half ? half_sec_tick : sec_tick;
  wire alarm_fire = alarm_config_repeat_ff.en & alarm_tick & digit_match;

  // alarm sequencing; a bus write to the config wins over the sequencer
  wire rpt_zero = alarm_config_repeat_ff.rpt == RPT_LAST;
  rca_alcfg_s nxt_cfg;
  always_comb begin
    nxt_cfg = alarm_config_repeat_ff;
    if (wr_cfg) begin
      nxt_cfg     = rca_alcfg_s'(wr_word[15:0]);
      nxt_cfg.rsv = 2'b00;
    end else if (alarm_fire) begin
      if (!rpt_zero)
        nxt_cfg.rpt = alarm_config_repeat_ff.rpt - 8'h01;
      else if (alarm_config_repeat_ff.endless_repeat)
        nxt_cfg.rpt = RPT_ROLL;
      else
        nxt_cfg.en = 1'b0;
    end
  end

  // calibration, applied as the seconds digits roll past the minute
  wire        minute_edge = sec_tick & (clock_now.sec == SEC_LAST);
  wire [11:0] cal_x4   = {{2{rtc_config_calibration_ff[7]}}, rtc_config_calibration_ff, 2'b00};
  wire        cal_neg  = rtc_config_calibration_ff[7];
  wire [11:0] cal_mag  = cal_neg ? 12'(~cal_x4 + 12'h001) : cal_x4;
  wire        cal_nz   = |rtc_config_calibration_ff;
  rca_cal_adj_s nxt_cal_adj;
  assign nxt_cal_adj.sub   = minute_edge & cal_nz & cal_neg;
  assign nxt_cal_adj.add   = minute_edge & cal_nz & ~cal_neg;
  assign nxt_cal_adj.count = (minute_edge & cal_nz) ? cal_mag[9:0] : 10'h000;

  // sticky interrupt status; a new event wins over a clear in the same cycle
  wire [1:0] irq_events = {nxt_cal_adj.sub | nxt_cal_adj.add, alarm_fire};
  wire [1:0] nxt_stat   = (irq_stat_ff & ~(wr_stat ? w1c_bits[1:0] : 2'b00)) | irq_events;
  wire [1:0] nxt_mask   = wr_mask ? wr_word[1:0] : irq_mask_ff;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rtc_config_calibration_ff <= CAL_RST;
      alarm_config_repeat_ff    <= rca_alcfg_s'(ALCFG_RST);
      alarm_value_ff            <= rca_time_s'(ALVAL_RST);
      irq_stat_ff               <= IRQ_RST;
      irq_mask_ff               <= IRQ_RST;
      irq_ff                    <= 1'b0;
      cal_adj_ff                <= '0;
      alarm_pulse_ff            <= 1'b0;
    end else begin
      if (wr_cal)
        rtc_config_calibration_ff <= wr_word[7:0];
      if (wr_time)
        {alarm_value_ff.hour, alarm_value_ff.min, alarm_value_ff.sec} <= wr_word[23:0];
      if (wr_date)
        {alarm_value_ff.month, alarm_value_ff.day, alarm_value_ff.wday} <= wr_word[23:0];
      alarm_config_repeat_ff <= nxt_cfg;
      irq_stat_ff            <= nxt_stat;
      irq_mask_ff            <= nxt_mask;
      irq_ff                 <= |(nxt_stat & nxt_mask);
      cal_adj_ff             <= nxt_cal_adj;
      alarm_pulse_ff         <= alarm_pulse_ff ^ alarm_fire;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0;
      rresp_ff   <= RESP_OKAY;
      awaddr_ff  <= '0;
      wdata_ff   <= 32'h0;
      wstrb_ff   <= 4'h0;
    end else begin
      aw_got_ff  <= nxt_aw_got;
      w_got_ff   <= nxt_w_got;
      awready_ff <= ~nxt_aw_got & ~nxt_bvalid;
      wready_ff  <= ~nxt_w_got & ~nxt_bvalid;
      bvalid_ff  <= nxt_bvalid;
      arready_ff <= ~nxt_rvalid;
      rvalid_ff  <= nxt_rvalid;
      if (aw_take)
        awaddr_ff <= awaddr;
      if (w_take) begin
        wdata_ff <= wdata;
        wstrb_ff <= wstrb;
      end
      if (do_wr)
        bresp_ff <= wr_view[32] ? RESP_OKAY : RESP_SLVERR;
      if (ar_take) begin
        rdata_ff <= rd_view[31:0];
        rresp_ff <= rd_view[32] ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign cal_adj     = cal_adj_ff;
  assign alarm_pulse = alarm_pulse_ff;
  assign irq         = irq_ff;
  assign awready     = awready_ff;
  assign wready      = wready_ff;
  assign bvalid      = bvalid_ff;
  assign bresp       = bresp_ff;
  assign arready     = arready_ff;
  assign rvalid      = rvalid_ff;
  assign rdata       = rdata_ff;
  assign rresp       = rresp_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  alarm_last_off_a: assert property (alarm_fire && rpt_zero && !alarm_config_repeat_ff.endless_repeat && !wr_cfg
    |=> !alarm_config_repeat_ff.en) else $error("alarm stayed enabled after last alarm");
  rpt_decrement_a: assert property (alarm_fire && !rpt_zero && !wr_cfg
    |=> alarm_config_repeat_ff.rpt == $past(alarm_config_repeat_ff.rpt) - 8'h01 && alarm_config_repeat_ff.en)
    else $error("repeat count not decremented");
  endless_repeat_roll_a: assert property (alarm_fire && rpt_zero && alarm_config_repeat_ff.endless_repeat && !wr_cfg
    |=> alarm_config_repeat_ff.rpt == RPT_ROLL && alarm_config_repeat_ff.en)
    else $error("endless_repeat did not roll count over");
  pulse_toggle_a: assert property (alarm_fire |=> alarm_pulse != $past(alarm_pulse))
    else $error("alarm pulse did not toggle");
  pulse_hold_a: assert property (!alarm_fire |=> $stable(alarm_pulse))
    else $error("alarm pulse changed without alarm");
  alarm_irq_a: assert property (alarm_fire && irq_mask_ff[IRQ_ALARM] && !wr_mask |=> irq && irq_stat_ff[IRQ_ALARM])
    else $error("alarm raised no interrupt");
  cal_subtract_a: assert property (minute_edge && cal_neg
    |=> cal_adj.sub && !cal_adj.add && cal_adj.count == 10'(-{{2{$past(cal_x4[11])}}, $past(cal_x4[9:0])}))
    else $error("negative calibration not subtracted");
  cal_add_a: assert property (minute_edge && cal_nz && !cal_neg
    |=> cal_adj.add && !cal_adj.sub && cal_adj.count == {$past(rtc_config_calibration_ff[7:0]), 2'b00})
    else $error("positive calibration not added");
  cal_quiet_a: assert property (!minute_edge |=> !cal_adj.add && !cal_adj.sub)
    else $error("calibration applied off the minute");
  no_fire_off_a: assert property (!alarm_config_repeat_ff.en
    |=> $stable(alarm_pulse) && !$rose(irq_stat_ff[IRQ_ALARM])) else $error("alarm fired while disabled");
  half_sec_fire_a: assert property (alarm_config_repeat_ff.en && cur_mask == RCA_M_HALF_SEC && half_sec_tick
    |=> alarm_pulse != $past(alarm_pulse)) else $error("half second alarm missed");

  endless_repeat_roll_c: cover property (alarm_fire && rpt_zero && alarm_config_repeat_ff.endless_repeat);
  last_alarm_c: cover property (alarm_fire && rpt_zero && !alarm_config_repeat_ff.endless_repeat);
  cal_sub_c:    cover property (cal_adj.sub);
  bus_read_c:   cover property (rvalid && rready);
endmodule : rca_top

// file: dv/rtc_calibration_and_alarm_tb_top.sv
/*
  self-checking bench for the clock calibration and alarm block.
  assumes rca_top with an axi4-lite slave and one-cycle ticks on mclk.
*/
`timescale 1ns/1ps
module rtc_calibration_and_alarm_tb_top;
  import rca_pkg::*;
  logic              mclk;
  logic              sys_rst;
  logic              half_sec_tick;
  logic              sec_tick;
  rca_time_s         clock_now;
  rca_cal_adj_s      cal_adj;
  logic              alarm_pulse;
  logic              irq;
  logic [ADDR_W-1:0] awaddr;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic [31:0]       wdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic [ADDR_W-1:0] araddr;
  logic              arvalid, arready, rvalid, rready;
  logic [31:0]       rdata;
  int                fails, n_checks, cycles;
  logic              ap_exp;
  logic [31:0]       rv;
  logic [1:0]        rs;
  // calibration byte beside the adjust word it must give: {add,sub,count}
  logic [19:0]       cal_rows [5] = '{20'h01_804, 20'hff_404, 20'h7f_9fc, 20'h80_600, 20'h00_000};
  // digit mask code, a clock that must match, a near miss; alarm value is 07_18_03_12_34_56
  logic [99:0]       mode_rows [8] = '{
    {4'h2, 48'h0000_0000_0046, 48'h0718_0312_3457},
    {4'h3, 48'h0000_0000_0056, 48'h0718_0312_3446},
    {4'h4, 48'h0000_0000_0456, 48'h0718_0312_3556},
    {4'h5, 48'h0000_0000_3456, 48'h0718_0312_2456},
    {4'h6, 48'h0000_0012_3456, 48'h0718_0313_3456},
    {4'h7, 48'h0000_0312_3456, 48'h0718_0412_3456},
    {4'h8, 48'h0018_0012_3456, 48'h0719_0312_3456},
    {4'h9, 48'h0718_0012_3456, 48'h0818_0312_3456}};

  rca_top u_dut (.mclk(mclk), .sys_rst(sys_rst), .half_sec_tick(half_sec_tick), .sec_tick(sec_tick),
    .clock_now(clock_now), .cal_adj(cal_adj), .alarm_pulse(alarm_pulse), .irq(irq),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  // hang guard: whole run needs well under this many cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      finish_test();
    end
  end

  // handshake inputs are judged half a cycle before the edge that takes them
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, ha, hw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge mclk);
    awaddr <= a; wdata <= d; wstrb <= 4'hf;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge mclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      @(posedge mclk);
      if (ha) begin awvalid <= 1'b0; ta = 1'b1; end
      if (hw) begin wvalid <= 1'b0; tw = 1'b1; end
    end
    do @(negedge mclk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge mclk);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(negedge mclk); while (arready !== 1'b1);
    @(posedge mclk);
    arvalid <= 1'b0;
    do @(negedge mclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge mclk);
    rready <= 1'b0;
  endtask : rd

  task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, rs);
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
  endtask : wr_ok

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    rd(a, rv, rs);
    chk(rv, e);
  endtask : rd_chk

  // one tick, then look just after the edge that fires on it
  task automatic tick(input logic half, input logic fire);
    @(posedge mclk);
    if (half) half_sec_tick <= 1'b1;
    else sec_tick <= 1'b1;
    @(posedge mclk);
    half_sec_tick <= 1'b0;
    sec_tick <= 1'b0;
    #1;
    if (fire) ap_exp = ~ap_exp;
    chk({31'h0, alarm_pulse}, {31'h0, ap_exp});
  endtask : tick

  initial begin
    fails = 0; n_checks = 0; cycles = 0; ap_exp = 1'b0;
    sys_rst = 1'b1; half_sec_tick = 1'b0; sec_tick = 1'b0; clock_now = '0;
    awaddr = '0; awvalid = 1'b0; wdata = '0; wstrb = '0; wvalid = 1'b0; bready = 1'b0;
    araddr = '0; arvalid = 1'b0; rready = 1'b0;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    foreach (cal_rows[i]) rd_chk(ADDR_CAL, 32'h0);
    rd_chk(ADDR_ALCFG, 32'h0);
    rd_chk(ADDR_STAT, 32'h0);
    rd_chk(ADDR_MASK, 32'h0);
    $display("test reset done");

    // calibration rows: the adjust word shows one cycle after the minute tick only
    clock_now.sec <= SEC_LAST;
    foreach (cal_rows[i]) begin
      wr_ok(ADDR_CAL, {24'h0, cal_rows[i][19:12]});
      tick(1'b0, 1'b0);
      chk({20'h0, cal_adj}, {20'h0, cal_rows[i][11:0]});
      @(posedge mclk);
      #1;
      chk({20'h0, cal_adj}, 32'h0);
    end
    wr_ok(ADDR_CAL, 32'h01);
    clock_now.sec <= 8'h58;
    tick(1'b0, 1'b0);
    chk({20'h0, cal_adj}, 32'h0);
    wr_ok(ADDR_CAL, 32'h0);
    rd_chk(ADDR_STAT, 32'h2);
    wr_ok(ADDR_STAT, 32'h3);
    $display("test calibration done");

    // single alarm on a seconds-digit match, then enable drops
    wr_ok(ADDR_ALTIME, 32'h30);
    wr_ok(ADDR_ALCFG, 32'h8c00);
    clock_now.sec <= 8'h31;
    tick(1'b0, 1'b0);
    @(posedge mclk);
    clock_now.sec <= 8'h30;
    tick(1'b0, 1'b1);
    rd_chk(ADDR_ALCFG, 32'h0c00);
    tick(1'b0, 1'b0);
    rd_chk(ADDR_STAT, 32'h1);
    $display("test single alarm done");

    // counted repeat: count 2 gives three alarms
    wr_ok(ADDR_ALCFG, 32'h8402);
    tick(1'b0, 1'b1);
    rd_chk(ADDR_ALCFG, 32'h8401);
    tick(1'b0, 1'b1);
    rd_chk(ADDR_ALCFG, 32'h8400);
    tick(1'b0, 1'b1);
    rd_chk(ADDR_ALCFG, 32'h0400);
    tick(1'b0, 1'b0);
    wr_ok(ADDR_ALCFG, 32'h84ff);
    tick(1'b0, 1'b1);
    rd_chk(ADDR_ALCFG, 32'h84fe);
    $display("test repeat done");

    // endless repeat rolls the count instead of disabling
    wr_ok(ADDR_ALCFG, 32'hc400);
    tick(1'b0, 1'b1);
    rd_chk(ADDR_ALCFG, 32'hc4ff);
    tick(1'b0, 1'b1);
    rd_chk(ADDR_ALCFG, 32'hc4fe);
    // half-second mode takes the half tick, not the second one
    wr_ok(ADDR_ALCFG, 32'h8001);
    tick(1'b0, 1'b0);
    tick(1'b1, 1'b1);
    rd_chk(ADDR_ALCFG, 32'h8000);
    tick(1'b1, 1'b1);
    rd_chk(ADDR_ALCFG, 32'h0);
    // reserved mask code never fires
    wr_ok(ADDR_ALCFG, 32'ha800);
    tick(1'b0, 1'b0);
    wr_ok(ADDR_ALCFG, 32'h0);
    $display("test modes done");

    // digit masks: a near miss stays quiet, then a match fires the single alarm
    wr_ok(ADDR_ALTIME, 32'h12_3456);
    wr_ok(ADDR_ALDATE, 32'h07_1803);
    rd_chk(ADDR_ALDATE, 32'h07_1803);
    foreach (mode_rows[i]) begin
      wr_ok(ADDR_ALCFG, {16'h0, 2'b10, mode_rows[i][99:96], 10'h000});
      clock_now <= mode_rows[i][47:0];
      tick(1'b0, 1'b0);
      @(posedge mclk);
      clock_now <= mode_rows[i][95:48];
      tick(1'b0, 1'b1);
      rd_chk(ADDR_ALCFG, {16'h0, 2'b00, mode_rows[i][99:96], 10'h000});
    end
    $display("test digit masks done");

    // interrupt: raised while unmasked status set, cleared by w1c or mask
    wr_ok(ADDR_MASK, 32'h1);
    repeat (2) @(posedge mclk);
    #1;
    chk({31'h0, irq}, 32'h1);
    wr_ok(ADDR_STAT, 32'h1);
    repeat (2) @(posedge mclk);
    #1;
    chk({31'h0, irq}, 32'h0);
    wr_ok(ADDR_ALCFG, 32'h8400);
    tick(1'b0, 1'b1);
    @(posedge mclk);
    #1;
    chk({31'h0, irq}, 32'h1);
    wr_ok(ADDR_MASK, 32'h0);
    repeat (2) @(posedge mclk);
    #1;
    chk({31'h0, irq}, 32'h0);
    rd_chk(ADDR_STAT, 32'h1);
    $display("test interrupt done");

    // mid-run reset returns registers and outputs to their idle values
    wr_ok(ADDR_CAL, 32'h05);
    wr_ok(ADDR_MASK, 32'h1);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, alarm_pulse}, 32'h0);
    chk({20'h0, cal_adj}, 32'h0);
    ap_exp = 1'b0;
    rd_chk(ADDR_CAL, 32'h0);
    rd_chk(ADDR_STAT, 32'h0);
    rd_chk(ADDR_MASK, 32'h0);
    rd_chk(ADDR_ALTIME, 32'h0);
    $display("test mid-run reset done");

    // unmapped place: error response, write ignored, reads zero
    wr(8'h40, 32'hffff_ffff, rs);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    rd(8'h40, rv, rs);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    chk(rv, 32'h0);
    rd_chk(ADDR_CAL, 32'h0);
    $display("test unmapped done");
    finish_test();
  end
endmodule : rtc_calibration_and_alarm_tb_top
